/* File: bench/tb_top.sv */
// self-checking bench for the thermal throttle control block
`timescale 1ns/1ns
`default_nettype none
`include "ttc_defs.svh"
module tb_top;
    logic sys_clk = 1'h0;
    logic rstn = 1'h0;
    logic [9:0] reg_addr = 10'h0;
    logic [63:0] reg_wdata = 64'h0;
    logic reg_wr = 1'h0;
    logic reg_rd = 1'h0;
    logic perfmon_avail = 1'h1;
    logic clk_en = 1'h1;
    logic [7:0] die_temp = 8'h20;
    logic g;
    wire logic [63:0] reg_rdata;
    wire logic sensor_hot, clk_gate, freq_req, throttle_active, irq;
    int miscompares = 0;
    int check_count = 0;
    ttc_sensor_model sns_u (.sys_clk, .die_temp, .sensor_hot);
    ttc_top dut_u (.sys_clk, .rstn, .clk_en, .reg_addr, .reg_wdata,
        .reg_wr, .reg_rd, .reg_rdata, .sensor_hot, .perfmon_avail,
        .clk_gate, .freq_req, .throttle_active, .irq);
    initial begin
        forever #4 sys_clk = ~sys_clk;
    end
    task chk(input logic [63:0] got, input logic [63:0] exp);
        check_count++;
        if (got !== exp) begin
            miscompares++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task cyc(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask : cyc
    task wr(input logic [9:0] a, input logic [63:0] d);
        @(posedge sys_clk);
        reg_wr <= 1'h1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge sys_clk);
        reg_wr <= 1'h0;
    endtask : wr
    task rd(input logic [9:0] a, input logic [63:0] exp);
        @(posedge sys_clk);
        reg_rd <= 1'h1;
        reg_addr <= a;
        cyc(1);
        reg_rd <= 1'h0;
        chk(reg_rdata, exp);
    endtask : rd
    task end_of_test;
        if (miscompares == 0 && check_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : end_of_test
    initial begin
        #5000;
        miscompares++;
        end_of_test;
    end
    initial begin
        cyc(12);
        rstn <= 1'h1;
        cyc(4);
        rd(`TTC_OFF_MISC, 64'h80);
        rd(10'h3ff, 64'h0);
        wr(`TTC_OFF_IMASK, 64'h2);
        die_temp <= 8'h70;
        cyc(8);
        chk(throttle_active, 1'h0);
        wr(`TTC_OFF_MISC, 64'h8);
        rd(`TTC_OFF_MISC, 64'h88);
        chk(throttle_active, 1'h1);
        chk(freq_req, 1'h0);
        g = clk_gate;
        cyc(1);
        chk(clk_gate ^ g, 1'h1);
        chk(irq, 1'h1);
        rd(`TTC_OFF_STATUS, 64'h3);
        chk(irq, 1'h0);
        wr(`TTC_OFF_MODE, 64'h1_0000);
        cyc(2);
        chk(freq_req, 1'h1);
        rd(`TTC_OFF_MODE, 64'h1_0000);
        die_temp <= 8'h20;
        cyc(5);
        chk(throttle_active, 1'h0);
        chk(irq, 1'h0);
        rd(`TTC_OFF_STATUS, 64'h4);
        die_temp <= 8'h70;
        cyc(6);
        wr(`TTC_OFF_MISC, 64'h0);
        cyc(3);
        chk(throttle_active, 1'h0);
        perfmon_avail <= 1'h0;
        cyc(5);
        rd(`TTC_OFF_MISC, 64'h0);
        rd(`TTC_OFF_IMASK, 64'h2);
        // a write while the clock enable is low must leave the mode alone
        clk_en <= 1'h0;
        wr(`TTC_OFF_MODE, 64'h0);
        clk_en <= 1'h1;
        rd(`TTC_OFF_MODE, 64'h1_0000);
        end_of_test;
    end
endmodule : tb_top
`default_nettype wire

/* File: bench/ttc_monitor.sv */
// port checker for the thermal throttle control block
`timescale 1ns/1ns
`default_nettype none
`include "ttc_defs.svh"
module ttc_monitor (
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic [9:0] reg_addr,
    input wire logic [63:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [63:0] reg_rdata,
    input wire logic sensor_hot,
    input wire logic perfmon_avail,
    input wire logic clk_gate,
    input wire logic freq_req,
    input wire logic throttle_active
);
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rstn);
    wire logic mwr = reg_wr && reg_addr == `TTC_OFF_MISC;
    wire logic mrd = reg_rd && reg_addr == `TTC_OFF_MISC;
    wire logic duty = throttle_active && !freq_req;
    a_idle_open: assert property (
        !throttle_active |-> clk_gate && !freq_req) else $error("gated idle");
    a_freq_mode: assert property (
        freq_req |-> throttle_active && clk_gate) else $error("bad freq");
    a_half_duty: assert property (
        duty && $past(duty) |-> clk_gate != $past(clk_gate))
        else $error("no half duty");
    a_off_idle: assert property (
        mwr && !reg_wdata[3] |-> ##2 !throttle_active) else $error("on");
    a_hot_start: assert property (
        sensor_hot[*3] ##0 (mwr && reg_wdata[3]) |-> ##2 throttle_active)
        else $error("no start");
    a_cool_stop: assert property (
        (!sensor_hot)[*3] |=> !throttle_active) else $error("no stop");
    a_en_back: assert property (
        mwr ##1 !mwr ##1 mrd |=> reg_rdata[3] == $past(reg_wdata[3], 3))
        else $error("enable lost");
    a_pmon_bit: assert property (
        mrd && $past(rstn, 2) && perfmon_avail == $past(perfmon_avail, 2)
        |=> reg_rdata[7] == $past(perfmon_avail)) else $error("pmon");
    cover property (duty);
    cover property (freq_req);
    cover property ($fell(throttle_active));
endmodule : ttc_monitor
bind ttc_top ttc_monitor mon_u (.*);
`default_nettype wire

/* File: bench/ttc_sensor_model.sv */
// thermal sensor model: trip comparator on die temperature
`timescale 1ns/1ns
`default_nettype none
module ttc_sensor_model #(parameter logic [7:0] TRIP = 8'h64) (
    input wire logic sys_clk,
    input wire logic [7:0] die_temp,
    output logic sensor_hot
);
    // registered so the trip edge always lands on a sys_clk rising edge
    always_ff @(posedge sys_clk) sensor_hot <= die_temp >= TRIP;
endmodule : ttc_sensor_model
`default_nettype wire

/* File: core/ttc_ctl_if.sv */
// control signals between the register file and the throttle engine
`timescale 1ns/1ns
`default_nettype none
interface ttc_ctl_if;
    logic enable;
    logic method;
    logic hot;
    logic active;
    logic gate;
    logic freq_req;
    modport regs (output enable, output method, output hot,
                  input active, input gate, input freq_req);
    modport eng (input enable, input method, input hot,
                 output active, output gate, output freq_req);
endinterface : ttc_ctl_if
`default_nettype wire

/* File: core/ttc_defs.svh */
// constants for the thermal throttle control block
`ifndef TTC_DEFS_SVH
`define TTC_DEFS_SVH

`define TTC_ADDR_W 10
`define TTC_DATA_W 64
`define TTC_OFF_STATUS 10'h19c
`define TTC_OFF_MODE 10'h19d
`define TTC_OFF_MISC 10'h1a0
`define TTC_OFF_IMASK 10'h1a4

`define TTC_MODE_SEL_BIT 16
`define TTC_MISC_EN_BIT 3
`define TTC_MISC_PMON_BIT 7

`define TTC_ST_HOT_BIT 0
`define TTC_ST_HOTLOG_BIT 1
`define TTC_ST_COOLLOG_BIT 2
`define TTC_EV_W 2
`define TTC_EV_HOT 0
`define TTC_EV_COOL 1

`define TTC_DUTY_HALF 1'h1

`endif

/* File: core/ttc_engine.sv */
// throttle engine: state machine and 50 percent clock gate
`timescale 1ns/1ns
`default_nettype none
`include "ttc_defs.svh"
module ttc_engine
    import ttc_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic clk_en,
    ttc_ctl_if.eng ctl
);
    ttc_state_e state_r;
    ttc_state_e state_nxt;
    logic phase_r;
    wire armed_hot = ctl.enable & ctl.hot;

    always_comb begin
        state_nxt = TTC_IDLE;
        unique case (state_r)
            TTC_IDLE, TTC_DUTY, TTC_FREQ: begin
                if (armed_hot) begin
                    state_nxt = ctl.method ? TTC_FREQ : TTC_DUTY;
                end else begin
                    state_nxt = TTC_IDLE;
                end
            end
            default: state_nxt = TTC_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            state_r <= TTC_IDLE;
            phase_r <= 1'h0;
        end else if (clk_en) begin
            state_r <= state_nxt;
            // phase toggles only while modulating so every burst starts low
            phase_r <= (state_nxt == TTC_DUTY) ? ~phase_r : 1'h0;
        end
    end

    assign ctl.active = (state_r != TTC_IDLE);
    // gate high means the core clock passes; half the cycles in duty mode
    assign ctl.gate = (state_r == TTC_DUTY) ? (phase_r ^ `TTC_DUTY_HALF)
                                            : 1'h1;
    assign ctl.freq_req = (state_r == TTC_FREQ);
endmodule : ttc_engine
`default_nettype wire

/* File: core/ttc_pkg.sv */
// types for the thermal throttle control block
package ttc_pkg;
    typedef enum logic [1:0] {
        TTC_IDLE = 2'b00,
        TTC_DUTY = 2'b01,
        TTC_FREQ = 2'b10
    } ttc_state_e;
endpackage : ttc_pkg

/* File: core/ttc_top.sv */
// thermal throttle control: registers, sensor sync, interrupt
// Operation
// - bit 16 of the mode register picks duty-cycle (0) or frequency (1).
// - with the enable bit clear, neither throttling method is ever used.
// - bit 3 of the feature register is a read-write enable, reset to 0.
// - when enabled, throttling starts whenever the sensor reports hot.
// - duty-cycle throttling gates the core clock to a 50% duty cycle.
// - bit 7 of the feature register reads whether perf monitoring exists.
//
// The implementer's own choice: the address-and-strobe port.
`timescale 1ns/1ns
`default_nettype none
`include "ttc_defs.svh"
module ttc_top
    import ttc_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic clk_en,
    input wire logic [`TTC_ADDR_W-1:0] reg_addr,
    input wire logic [`TTC_DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [`TTC_DATA_W-1:0] reg_rdata,
    input wire logic sensor_hot,
    input wire logic perfmon_avail,
    output logic clk_gate,
    output logic freq_req,
    output logic throttle_active,
    output logic irq
);
    ttc_ctl_if ctl();

    logic hot_s1_r;
    logic hot_s2_r;
    logic hot_d_r;
    logic pm_s1_r;
    logic pm_s2_r;
    logic enable_r;
    logic method_r;
    logic [`TTC_EV_W-1:0] sticky_r;
    logic [`TTC_EV_W-1:0] mask_r;
    logic [`TTC_DATA_W-1:0] rdata_r;

    function automatic logic hit(input logic [`TTC_ADDR_W-1:0] a,
                                 input logic [`TTC_ADDR_W-1:0] off);
        hit = (a == off);
    endfunction : hit

    wire wr_mode = reg_wr & hit(reg_addr, `TTC_OFF_MODE);
    wire wr_misc = reg_wr & hit(reg_addr, `TTC_OFF_MISC);
    wire wr_mask = reg_wr & hit(reg_addr, `TTC_OFF_IMASK);
    wire rd_stat = reg_rd & hit(reg_addr, `TTC_OFF_STATUS);

    wire [`TTC_EV_W-1:0] events = {hot_d_r & ~hot_s2_r,
                                   ~hot_d_r & hot_s2_r};

    wire [`TTC_DATA_W-1:0] stat_word =
        (`TTC_DATA_W'(hot_s2_r) << `TTC_ST_HOT_BIT) |
        (`TTC_DATA_W'(sticky_r[`TTC_EV_HOT]) << `TTC_ST_HOTLOG_BIT) |
        (`TTC_DATA_W'(sticky_r[`TTC_EV_COOL]) << `TTC_ST_COOLLOG_BIT);
    wire [`TTC_DATA_W-1:0] mode_word =
        `TTC_DATA_W'(method_r) << `TTC_MODE_SEL_BIT;
    wire [`TTC_DATA_W-1:0] misc_word =
        (`TTC_DATA_W'(enable_r) << `TTC_MISC_EN_BIT) |
        (`TTC_DATA_W'(pm_s2_r) << `TTC_MISC_PMON_BIT);
    // mask bits sit right under the sticky bits they gate
    wire [`TTC_DATA_W-1:0] mask_word =
        (`TTC_DATA_W'(mask_r[`TTC_EV_HOT]) << `TTC_ST_HOTLOG_BIT) |
        (`TTC_DATA_W'(mask_r[`TTC_EV_COOL]) << `TTC_ST_COOLLOG_BIT);

    // unmapped addresses read as zero
    wire [`TTC_DATA_W-1:0] rd_mux =
        hit(reg_addr, `TTC_OFF_STATUS) ? stat_word :
        hit(reg_addr, `TTC_OFF_MODE) ? mode_word :
        hit(reg_addr, `TTC_OFF_MISC) ? misc_word :
        hit(reg_addr, `TTC_OFF_IMASK) ? mask_word : '0;

    // sensor and strap are asynchronous pins: two-stage sync
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            hot_s1_r <= 1'h0;
            hot_s2_r <= 1'h0;
            hot_d_r <= 1'h0;
            pm_s1_r <= 1'h0;
            pm_s2_r <= 1'h0;
        end else if (clk_en) begin
            hot_s1_r <= sensor_hot;
            hot_s2_r <= hot_s1_r;
            hot_d_r <= hot_s2_r;
            pm_s1_r <= perfmon_avail;
            pm_s2_r <= pm_s1_r;
        end
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            enable_r <= 1'h0;
            method_r <= 1'h0;
            mask_r <= '0;
        end else if (clk_en) begin
            if (wr_misc) begin
                enable_r <= reg_wdata[`TTC_MISC_EN_BIT];
            end
            if (wr_mode) begin
                method_r <= reg_wdata[`TTC_MODE_SEL_BIT];
            end
            if (wr_mask) begin
                mask_r <= {reg_wdata[`TTC_ST_COOLLOG_BIT],
                           reg_wdata[`TTC_ST_HOTLOG_BIT]};
            end
        end
    end

    // a new event in the clearing read cycle survives the clear
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            sticky_r <= '0;
        end else if (clk_en) begin
            sticky_r <= (rd_stat ? '0 : sticky_r) | events;
        end
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            rdata_r <= '0;
        end else if (clk_en) begin
            rdata_r <= reg_rd ? rd_mux : '0;
        end
    end

    assign ctl.enable = enable_r;
    assign ctl.method = method_r;
    assign ctl.hot = hot_s2_r;

    ttc_engine u_engine (
        .sys_clk(sys_clk),
        .rstn(rstn),
        .clk_en(clk_en),
        .ctl(ctl)
    );

    assign reg_rdata = rdata_r;
    assign clk_gate = ctl.gate;
    assign freq_req = ctl.freq_req;
    assign throttle_active = ctl.active;
    assign irq = |(sticky_r & mask_r);
endmodule : ttc_top
`default_nettype wire
